// ===== rtl/cemask_pkg.sv
`default_nettype none
package cemask_pkg;

  // register offsets
  localparam logic [7:0] MASK_C_ADDR = 8'h2a;
  localparam logic [7:0] MASK_D_ADDR = 8'h2b;
  localparam logic [7:0] MASK_A_ADDR = 8'h2c;

  // reset values
  localparam logic [7:0] MASK_C_RST  = 8'h00;
  localparam logic [7:0] MASK_D_RST  = 8'h00;
  localparam logic [7:0] MASK_A_RST  = 8'h00;

  // writable bits; the rest read zero
  localparam logic [7:0] MASK_C_WMSK = 8'h7f;
  localparam logic [7:0] MASK_D_WMSK = 8'h1f;
  localparam logic [7:0] MASK_A_WMSK = 8'hff;

  // charger_event_mask_c field positions
  localparam int C_DATALINE  = 6;
  localparam int C_CONVDONE  = 5;
  localparam int C_MINSYS    = 4;
  localparam int C_FASTTMR   = 3;
  localparam int C_TRICKTMR  = 2;
  localparam int C_PRETMR    = 1;
  localparam int C_TOPTMR    = 0;
  // charger_event_mask_d field positions
  localparam int D_BOOSTLOW  = 4;
  localparam int D_COLD      = 3;
  localparam int D_COOL      = 2;
  localparam int D_WARM      = 1;
  localparam int D_HOT       = 0;
  // fault_event_mask_a field positions
  localparam int A_BATCURLOOP = 7;
  localparam int A_BUSOVERV   = 6;
  localparam int A_BATOVERV   = 5;
  localparam int A_BUSOVERC   = 4;
  localparam int A_BATOVERC   = 3;
  localparam int A_CONVOVERC  = 2;
  localparam int A_ADPBOVERV  = 1;
  localparam int A_ADPAOVERV  = 0;

  // number of event sources
  localparam int NUM_EVT     = 20;

  // register read/write request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cemask_req_s;

endpackage : cemask_pkg
`default_nettype wire

// ===== rtl/cemask_edge.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser plus edge detector for one event line
module cemask_edge (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic level_in,
  input  wire logic both_in,
  output logic      pulse_out
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic rise_w;
  logic fall_w;

  // first flop read only by the second
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= level_in;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end

  assign rise_w    = sync_r & ~last_r;
  assign fall_w    = ~sync_r & last_r;
  // both edges when both_in is set: a loop entry or exit, or a thermistor crossing
  assign pulse_out = rise_w | (both_in & fall_w);

endmodule : cemask_edge
`default_nettype wire

// ===== rtl/cemask_top.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: dataline detection done pulses interrupt only when mask_c bit 6 is clear.
// R2: conversion done pulses only in single-conversion mode and mask_c bit 5 clear.
// R3: entering or leaving min-system loop pulses when mask_c bit 4 clear.
// R4: fast, trickle, pre, top-off timer expiry gated by mask_c bits 3..0.
// R5: all mask bits reset to zero.
// R6: battery too low for boost interrupts unless mask_d bit 4 set.
// R7: cold, cool, warm, hot crossings gated by mask_d bits 3..0.
// R8: mask_d bits 7..5 and mask_c bit 7 read zero, ignore writes.
// R9: entering or leaving battery-current loop interrupts unless mask_a bit 7.
// R10: input-bus overvoltage entry pulses unless mask_a bit 6 set.
// R11: battery overvoltage entry pulses unless mask_a bit 5 set.
// R12: input-bus overcurrent interrupts only when mask_a bit 4 clear.
// R13: battery overcurrent interrupts only when mask_a bit 3 clear.
// R14: converter overcurrent interrupts only when mask_a bit 2 clear.
// R15: adapter b and a overvoltage gated by mask_a bits 1 and 0.
// R16: masks gate only the pulse; event flags update regardless.
module cemask_top (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        reg_defaults_in,
  input  wire logic        watchdog_expired_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  input  wire logic [7:0]  reg_addr_in,
  input  wire logic [7:0]  reg_wdata_in,
  input  wire logic        single_conv_mode_in,
  input  wire logic [19:0] event_level_in,
  output logic [7:0]       reg_rdata_out,
  output logic             reg_rvalid_out,
  output logic [19:0]      event_flag_out,
  output logic             irq_pulse_out
);
  // event index map: c bits 6..0 -> 19..13, d bits 4..0 -> 12..8, a bits 7..0 -> 7..0
  logic [7:0]  mask_c_r;
  logic [7:0]  mask_c_nxt;
  logic [7:0]  mask_d_r;
  logic [7:0]  mask_d_nxt;
  logic [7:0]  mask_a_r;
  logic [7:0]  mask_a_nxt;
  logic [7:0]  rdata_nxt;
  logic [7:0]  rdata_r;
  logic        rvalid_r;
  logic [19:0] flag_r;
  logic        irq_r;
  logic [19:0] evt_pulse_w;
  logic [19:0] both_edge_w;
  logic [19:0] evt_mask_w;
  logic [19:0] evt_gate_w;
  logic        sel_c_w;
  logic        sel_d_w;
  logic        sel_a_w;
  logic        single_meta_r;
  logic        single_sync_r;
  // one named bit per mask field, so each gate reads by its event
  logic        dataline_detect_irq_block;
  logic        conv_done_irq_block;
  logic        min_system_loop_irq_block;
  logic        fast_charge_timer_irq_block;
  logic        trickle_timer_irq_block;
  logic        precharge_timer_irq_block;
  logic        topoff_timer_irq_block;
  logic        boost_low_battery_irq_block;
  logic        therm_cold_irq_block;
  logic        therm_cool_irq_block;
  logic        therm_warm_irq_block;
  logic        therm_hot_irq_block;
  logic        battery_current_loop_irq_block;
  logic        input_bus_overvolt_irq_block;
  logic        battery_overvolt_irq_block;
  logic        input_bus_overcurrent_irq_block;
  logic        battery_overcurrent_irq_block;
  logic        converter_overcurrent_irq_block;
  logic        adapter_b_overvolt_irq_block;
  logic        adapter_a_overvolt_irq_block;
  cemask_pkg::cemask_req_s req_w;

  // masked write keeps reserved bits at zero
  function automatic logic [7:0] wr_merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic [7:0] wmsk);
    wr_merge = (new_v & wmsk) | (old_v & ~wmsk);
  endfunction : wr_merge

  assign req_w = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};

  // address decode
  assign sel_c_w = (req_w.addr == cemask_pkg::MASK_C_ADDR);
  assign sel_d_w = (req_w.addr == cemask_pkg::MASK_D_ADDR);
  assign sel_a_w = (req_w.addr == cemask_pkg::MASK_A_ADDR);

  // R5: defaults reload clears all masks
  // R8: reserved bits not writable
  assign mask_c_nxt = reg_defaults_in ? cemask_pkg::MASK_C_RST :
                      (req_w.wr && sel_c_w) ? wr_merge(mask_c_r, req_w.wdata, cemask_pkg::MASK_C_WMSK) :
                      mask_c_r;
  // R6: watchdog also clears boost and thermistor masks
  assign mask_d_nxt = (reg_defaults_in || watchdog_expired_in) ? cemask_pkg::MASK_D_RST :
                      (req_w.wr && sel_d_w) ? wr_merge(mask_d_r, req_w.wdata, cemask_pkg::MASK_D_WMSK) :
                      mask_d_r;
  assign mask_a_nxt = reg_defaults_in ? cemask_pkg::MASK_A_RST :
                      (req_w.wr && sel_a_w) ? wr_merge(mask_a_r, req_w.wdata, cemask_pkg::MASK_A_WMSK) :
                      mask_a_r;

  // read mux; unmapped addresses return zero
  assign rdata_nxt = !req_w.rd ? rdata_r :
                     sel_c_w ? (mask_c_r & cemask_pkg::MASK_C_WMSK) :
                     sel_d_w ? (mask_d_r & cemask_pkg::MASK_D_WMSK) :
                     sel_a_w ? mask_a_r :
                     8'h00;

  // R5: mask registers zero at power-up
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mask_c_r <= cemask_pkg::MASK_C_RST;
      mask_d_r <= cemask_pkg::MASK_D_RST;
      mask_a_r <= cemask_pkg::MASK_A_RST;
    end else begin
      mask_c_r <= mask_c_nxt;
      mask_d_r <= mask_d_nxt;
      mask_a_r <= mask_a_nxt;
    end
  end

  // read data registered, one cycle after the strobe
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= req_w.rd;
    end
  end

  // mode level comes from the converter block, synchronised
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      single_meta_r <= 1'b0;
      single_sync_r <= 1'b0;
    end else begin
      single_meta_r <= single_conv_mode_in;
      single_sync_r <= single_meta_r;
    end
  end

  // R3: min-system loop pulses on both edges
  // R9: battery-current loop pulses on both edges
  // R7: thermistor crossings counted in both directions
  assign both_edge_w = 20'h20f80; // bits 17, 11..8 and 7

  // per-event synchroniser and edge detector
  for (genvar i = 0; i < cemask_pkg::NUM_EVT; i++) begin : g_evt
    cemask_edge u_edge (
      .ref_clk_in (ref_clk_in),
      .sys_rst_in (sys_rst_in),
      .level_in   (event_level_in[i]),
      .both_in    (both_edge_w[i]),
      .pulse_out  (evt_pulse_w[i])
    );
  end

  // R1: dataline done mask
  assign dataline_detect_irq_block       = mask_c_r[cemask_pkg::C_DATALINE];
  // R2: conversion done mask
  assign conv_done_irq_block             = mask_c_r[cemask_pkg::C_CONVDONE];
  // R3: min-system loop mask
  assign min_system_loop_irq_block       = mask_c_r[cemask_pkg::C_MINSYS];
  // R4: safety timer masks
  assign fast_charge_timer_irq_block     = mask_c_r[cemask_pkg::C_FASTTMR];
  assign trickle_timer_irq_block         = mask_c_r[cemask_pkg::C_TRICKTMR];
  assign precharge_timer_irq_block       = mask_c_r[cemask_pkg::C_PRETMR];
  assign topoff_timer_irq_block          = mask_c_r[cemask_pkg::C_TOPTMR];
  // R6: boost low-battery mask
  assign boost_low_battery_irq_block     = mask_d_r[cemask_pkg::D_BOOSTLOW];
  // R7: thermistor crossing masks
  assign therm_cold_irq_block            = mask_d_r[cemask_pkg::D_COLD];
  assign therm_cool_irq_block            = mask_d_r[cemask_pkg::D_COOL];
  assign therm_warm_irq_block            = mask_d_r[cemask_pkg::D_WARM];
  assign therm_hot_irq_block             = mask_d_r[cemask_pkg::D_HOT];
  // R9: battery-current loop mask
  assign battery_current_loop_irq_block  = mask_a_r[cemask_pkg::A_BATCURLOOP];
  // R10: input-bus overvoltage mask
  assign input_bus_overvolt_irq_block    = mask_a_r[cemask_pkg::A_BUSOVERV];
  // R11: battery overvoltage mask
  assign battery_overvolt_irq_block      = mask_a_r[cemask_pkg::A_BATOVERV];
  // R12: input-bus overcurrent mask
  assign input_bus_overcurrent_irq_block = mask_a_r[cemask_pkg::A_BUSOVERC];
  // R13: battery overcurrent mask
  assign battery_overcurrent_irq_block   = mask_a_r[cemask_pkg::A_BATOVERC];
  // R14: converter overcurrent mask
  assign converter_overcurrent_irq_block = mask_a_r[cemask_pkg::A_CONVOVERC];
  // R15: adapter overvoltage masks
  assign adapter_b_overvolt_irq_block    = mask_a_r[cemask_pkg::A_ADPBOVERV];
  assign adapter_a_overvolt_irq_block    = mask_a_r[cemask_pkg::A_ADPAOVERV];

  // mask vector in event index order, 19 down to 0
  assign evt_mask_w = {dataline_detect_irq_block, conv_done_irq_block, min_system_loop_irq_block,
                       fast_charge_timer_irq_block, trickle_timer_irq_block, precharge_timer_irq_block,
                       topoff_timer_irq_block, boost_low_battery_irq_block, therm_cold_irq_block,
                       therm_cool_irq_block, therm_warm_irq_block, therm_hot_irq_block,
                       battery_current_loop_irq_block, input_bus_overvolt_irq_block, battery_overvolt_irq_block,
                       input_bus_overcurrent_irq_block, battery_overcurrent_irq_block,
                       converter_overcurrent_irq_block, adapter_b_overvolt_irq_block,
                       adapter_a_overvolt_irq_block};

  // R2: conversion done only counts in single-conversion mode
  assign evt_gate_w = evt_pulse_w & ~evt_mask_w
                    & ~(20'h40000 & {20{~single_sync_r}});

  // R16: flags set regardless of mask, set wins over read clear
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flag_r <= 20'h00000;
    end else begin
      flag_r <= evt_pulse_w | (flag_r & {20{~(req_w.rd && sel_a_w)}});
    end
  end

  // one-cycle interrupt pulse
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |evt_gate_w;
    end
  end

  assign reg_rdata_out  = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign event_flag_out = flag_r;
  assign irq_pulse_out  = irq_r;

endmodule : cemask_top
`default_nettype wire

// ===== tb/cemask_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks for the mask block
module cemask_chk (
  input wire logic        ref_clk_in,
  input wire logic        sys_rst_in,
  input wire logic        reg_defaults_in,
  input wire logic        watchdog_expired_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [19:0] event_level_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        reg_rvalid_out,
  input wire logic [19:0] event_flag_out,
  input wire logic        irq_pulse_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // decoded reads keep the properties short
  wire logic rd_c = reg_rd_in && reg_addr_in == cemask_pkg::MASK_C_ADDR;
  wire logic rd_d = reg_rd_in && reg_addr_in == cemask_pkg::MASK_D_ADDR;
  wire logic rd_a = reg_rd_in && reg_addr_in == cemask_pkg::MASK_A_ADDR;
  a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read unanswered");
  a_resv_c_zero: assert property (rd_c |=> !reg_rdata_out[7]) else $error("mask c bit 7 set");
  a_resv_d_zero: assert property (rd_d |=> reg_rdata_out[7:5] == 3'h0) else $error("mask d top set");
  a_unmapped_zero: assert property (reg_rd_in && !rd_c && !rd_d && !rd_a |=> reg_rdata_out == 8'h00)
    else $error("unmapped read nonzero");
  a_dflt_clear: assert property (reg_defaults_in ##1 (reg_rd_in && !reg_wr_in) |=> reg_rdata_out == 8'h00)
    else $error("defaults left a mask");
  a_wdog_clear: assert property (watchdog_expired_in ##1 (rd_d && !reg_wr_in) |=> reg_rdata_out == 8'h00)
    else $error("watchdog left mask d");
  // settled events must leave the pin quiet; 8 cycles covers the sync and edge stages
  a_quiet_irq: assert property ($stable(event_level_in) [*8] |-> !irq_pulse_out) else $error("irq without event");
  a_irq_flagged: assert property (irq_pulse_out |-> event_flag_out != 20'h0) else $error("irq without flag");
endmodule : cemask_chk
`default_nettype wire

// ===== tb/cemask_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side: tallies interrupt pulses, one per high cycle
module cemask_host (
  input  wire logic ref_clk_in,
  input  wire logic sys_rst_in,
  input  wire logic irq_in,
  output logic [7:0] irq_count_out
);
  // wraps at 255, far beyond any single check window
  always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) irq_count_out <= 8'h00;
    else if (irq_in) irq_count_out <= irq_count_out + 8'h01;
  end
endmodule : cemask_host
`default_nettype wire

// ===== tb/cemask_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
bind cemask_top cemask_chk chk_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .reg_defaults_in(reg_defaults_in),
  .watchdog_expired_in(watchdog_expired_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
  .event_level_in(event_level_in), .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
  .event_flag_out(event_flag_out), .irq_pulse_out(irq_pulse_out));
// register and event sequences against the mask block
module cemask_top_bench;
  localparam logic [19:0] both_edge = 20'h20f80;
  logic        clk = 1'b0, rst = 1'b1, dflt = 1'b0, wdog = 1'b0, wr = 1'b0, rd = 1'b0, conv = 1'b1, rv, irq;
  logic [7:0]  addr = 8'h00, wdat = 8'h00, rdat, cnt;
  logic [19:0] evt = 20'h0, flag;
  int          miscompares = 0, tests_run = 0;
  always #10 clk = ~clk;
  cemask_top dut_u (.ref_clk_in(clk), .sys_rst_in(rst), .reg_defaults_in(dflt), .watchdog_expired_in(wdog),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdat), .single_conv_mode_in(conv),
    .event_level_in(evt), .reg_rdata_out(rdat), .reg_rvalid_out(rv), .event_flag_out(flag), .irq_pulse_out(irq));
  cemask_host host_u (.ref_clk_in(clk), .sys_rst_in(rst), .irq_in(irq), .irq_count_out(cnt));
  task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wdat} = {1'b1, a, d};
    @(negedge clk);
    wr = 1'b0;
  endtask : wreg
  // answer lands one edge after the request
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    rd = 1'b0;
    chk("read valid", {19'h0, rv}, 20'h1);
    chk("read data", {12'h0, rdat}, {12'h0, exp});
  endtask : rreg
  // raise then drop one event, counting host pulses for each edge
  task automatic evt_try(input int i, input logic [7:0] n_rise, input logic [7:0] n_fall);
    logic [7:0] c0;
    c0 = cnt;
    evt[i] = 1'b1;
    repeat (8) @(negedge clk);
    chk("irq on rise", {12'h0, cnt - c0}, {12'h0, n_rise});
    c0 = cnt;
    evt[i] = 1'b0;
    repeat (8) @(negedge clk);
    chk("irq on fall", {12'h0, cnt - c0}, {12'h0, n_fall});
  endtask : evt_try
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // a hang ends as a failure
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end
  initial begin
    logic [7:0] ma;
    logic [7:0] mb;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 3; k++) begin
      rreg(cemask_pkg::MASK_C_ADDR + 8'(k), 8'h00);
      wreg(cemask_pkg::MASK_C_ADDR + 8'(k), 8'hff);
    end
    rreg(cemask_pkg::MASK_C_ADDR, 8'h7f);
    rreg(cemask_pkg::MASK_D_ADDR, 8'h1f);
    rreg(cemask_pkg::MASK_A_ADDR, 8'hff);
    rreg(8'h29, 8'h00);
    // watchdog clears mask d only
    // read strobe follows the clear by one cycle so the checker sees the pair
    wdog = 1'b1;
    fork
      rreg(cemask_pkg::MASK_D_ADDR, 8'h00);
      begin
        @(negedge clk);
        wdog = 1'b0;
      end
    join
    rreg(cemask_pkg::MASK_C_ADDR, 8'h7f);
    dflt = 1'b1;
    fork
      rreg(cemask_pkg::MASK_C_ADDR, 8'h00);
      begin
        @(negedge clk);
        dflt = 1'b0;
      end
    join
    rreg(cemask_pkg::MASK_A_ADDR, 8'h00);
    // each event masked by its own bit, then open
    for (int i = 0; i < 20; i++) begin
      ma = (i > 12) ? cemask_pkg::MASK_C_ADDR : (i > 7) ? cemask_pkg::MASK_D_ADDR : cemask_pkg::MASK_A_ADDR;
      mb = 8'h01 << ((i > 12) ? i - 13 : (i > 7) ? i - 8 : i);
      wreg(ma, mb);
      evt_try(i, 8'h00, 8'h00);
      chk("flag despite mask", {19'h0, flag[i]}, 20'h1);
      wreg(ma, 8'h00);
      evt_try(i, 8'h01, {7'h0, both_edge[i]});
    end
    // conversion done stays silent outside one-shot mode
    conv = 1'b0;
    repeat (4) @(negedge clk);
    evt_try(18, 8'h00, 8'h00);
    chk("flag outside one-shot", {19'h0, flag[18]}, 20'h1);
    // reading the fault mask clears the sticky flags
    rreg(cemask_pkg::MASK_A_ADDR, 8'h00);
    chk("flags after clear", flag, 20'h0);
    close_out();
  end
endmodule : cemask_top_bench
`default_nettype wire
